// ### pkg/idam_defs.svh
// register offsets, field positions, reset values and timing counts of the monitor
`ifndef IDAM_DEFS_SVH
`define IDAM_DEFS_SVH
`define ADR_THR1      7'h26
`define ADR_THR2      7'h28
`define ADR_SMP1      7'h2A
`define ADR_SMP2      7'h2C
`define ADR_ACTL      7'h2E
`define ADR_MSC       7'h34
`define ADR_DIAG      7'h3C
`define MSC_MEMTEST   11
`define MSC_SELFTEST  10
`define MSC_NEG       9
`define MSC_POS       8
`define DG_ALM2       9
`define DG_ALM1       8
`define DG_UNUSED     7
`define DG_FLASH      6
`define DG_STERR      5
`define DG_OVR        4
`define DG_COMM       3
`define DG_FUPD       2
`define THR_POL       15
`define RST_MSC       16'h0006
`define RST_ZERO      16'h0000
`define ST_SETTLE_MS  50
`define BASE_RATE_DSPS 8192
`define ST_SETTLE_TICKS ((`ST_SETTLE_MS * `BASE_RATE_DSPS + 9999) / 10000)
`endif

// ### pkg/idam_pkg.sv
// types shared by the diagnostics and alarm monitor
package idam_pkg;
   typedef logic [13:0] sample_t;
   // ch[k] carries the source selected by code k+1
   typedef struct packed {
      sample_t [10:0] ch;
   } sensor_set_s;
   typedef struct packed {
      logic [3:0] src2;
      logic [3:0] src1;
      logic       roc2;
      logic       roc1;
      logic       rsv5;
      logic       filt;
      logic       rsv3;
      logic       out_en;
      logic       out_pol;
      logic       out_sel;
   } alarm_ctrl_s;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_POS  = 5'h02,
      ST_NEG  = 5'h04,
      ST_EVAL = 5'h08,
      ST_MEM  = 5'h10
   } diag_state_e;
endpackage : idam_pkg

// ### logic/serial_link.sv
// serial link shift logic running on the host's serial clock
`timescale 1ns/1ns
module serial_link (
   input  wire logic        rstn_i,
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic        din_i,
   input  wire logic [15:0] tx_word_i,
   output logic             dout_o,
   output logic [15:0]      rx_word_o,
   output logic             frame_tgl_o
);
   logic [3:0]  rx_cnt_ff, nxt_rx_cnt;
   logic [14:0] rx_sh_ff, nxt_rx_sh;
   logic [15:0] nxt_rx_word;
   logic        nxt_tgl;
   logic [3:0]  tx_cnt_ff, nxt_tx_cnt;
   logic [14:0] tx_sh_ff, nxt_tx_sh;
   logic        nxt_dout;

   // sixteen rising edges make one word; the toggle tells the system clock side
   always_comb begin
      nxt_rx_cnt  = rx_cnt_ff + 4'h1;
      nxt_rx_sh   = {rx_sh_ff[13:0], din_i};
      nxt_rx_word = rx_word_o;
      nxt_tgl     = frame_tgl_o;
      if (rx_cnt_ff == 4'hF) begin
         nxt_rx_word = {rx_sh_ff, din_i};
         nxt_tgl     = ~frame_tgl_o;
      end
   end

   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         rx_cnt_ff <= 4'h0;
         rx_sh_ff  <= 15'h0000;
      end else begin
         rx_cnt_ff <= nxt_rx_cnt;
         rx_sh_ff  <= nxt_rx_sh;
      end
   end

   // word and toggle survive chip select so the other domain can pick them up
   always_ff @(posedge sclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_word_o   <= 16'h0000;
         frame_tgl_o <= 1'b0;
      end else begin
         rx_word_o   <= nxt_rx_word;
         frame_tgl_o <= nxt_tgl;
      end
   end

   // answer shifts out on falling edges; tx word is loaded at the first one of each frame
   always_comb begin
      nxt_tx_cnt = tx_cnt_ff + 4'h1;
      if (tx_cnt_ff == 4'h0) begin
         {nxt_dout, nxt_tx_sh} = tx_word_i;
      end else begin
         {nxt_dout, nxt_tx_sh} = {tx_sh_ff, 1'b0};
      end
   end

   always_ff @(negedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         tx_cnt_ff <= 4'h0;
         tx_sh_ff  <= 15'h0000;
         dout_o    <= 1'b0;
      end else begin
         tx_cnt_ff <= nxt_tx_cnt;
         tx_sh_ff  <= nxt_tx_sh;
         dout_o    <= nxt_dout;
      end
   end
endmodule : serial_link

// ### logic/idam_monitor.sv
// self-test, memory test, diagnostic status and alarm logic behind the serial link
`timescale 1ns/1ns
`include "idam_defs.svh"
module idam_monitor #(
   parameter logic [7:0] ST_PHASE_TICKS = 8'(`ST_SETTLE_TICKS)
) (
   input  wire logic                 SYS_CLK_I,
   input  wire logic                 RSTN_I,
   input  wire logic                 SCLK_I,
   input  wire logic                 CS_N_I,
   input  wire logic                 DIN_I,
   output logic                      DOUT_O,
   input  wire logic                 SAMPLE_TICK_I,
   input  wire idam_pkg::sensor_set_s SENS_RAW_I,
   input  wire idam_pkg::sensor_set_s SENS_FILT_I,
   input  wire logic [5:0]           ST_AXIS_FAIL_I,
   input  wire logic                 SUPPLY_HIGH_I,
   input  wire logic                 SUPPLY_LOW_I,
   input  wire logic                 OVERRANGE_I,
   input  wire logic                 FLASH_UPD_FAIL_I,
   input  wire logic                 FLASH_CHK_DONE_I,
   input  wire logic                 FLASH_CHK_FAIL_I,
   output logic                      STIM_POS_O,
   output logic                      STIM_NEG_O,
   output logic                      FLASH_CHK_START_O,
   output logic                      GP_LINE_1_O,
   output logic                      GP_LINE_1_OE_O,
   output logic                      GP_LINE_2_O,
   output logic                      GP_LINE_2_OE_O
);
   import idam_pkg::*;

   function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi,
                                            input logic [7:0] d);
      return hi ? {d, w[7:0]} : {w[15:8], d};
   endfunction : put_byte

   function automatic sample_t pick_src(input sensor_set_s s, input logic [3:0] code);
      if (code == 4'h0 || code > 4'hB) begin
         return 14'h0000;
      end
      return s.ch[code - 4'h1];
   endfunction : pick_src

   function automatic logic [7:0] eff_count(input logic [7:0] c);
      return (c <= 8'h01) ? 8'h01 : c;
   endfunction : eff_count

   function automatic logic over_thr(input logic pol, input logic signed [14:0] a,
                                     input logic signed [14:0] b);
      return pol ? (a > b) : (a < b);
   endfunction : over_thr

   logic [15:0]  rx_word;
   logic         frame_tgl;
   logic [2:0]   tgl_sync_ff;
   logic [2:0]   cs_sync_ff;
   logic [1:0]   sup_s1_ff, sup_s2_ff;
   logic         frame_evt, cs_rise, rd_evt, wr_evt, diag_rd, comm_evt;
   logic [6:0]   cmd_adr, cmd_word_adr;
   logic [15:0]  thr_ff [2];
   logic [15:0]  nxt_thr [2];
   logic [7:0]   smp_ff [2];
   logic [7:0]   nxt_smp [2];
   alarm_ctrl_s  actl_ff, nxt_actl;
   logic [15:0]  msc_ff, nxt_msc, tx_ff, nxt_tx;
   logic         seen_ff, nxt_seen;
   diag_state_e  st_ff, nxt_st;
   logic [7:0]   cnt_ff, nxt_cnt;
   logic [5:0]   axis_fail_ff, nxt_axis_fail;
   logic         st_done, mem_done;
   logic [1:0]   alm_ff, nxt_alm;
   sample_t      snap_ff [2];
   sample_t      nxt_snap [2];
   logic [7:0]   wcnt_ff [2];
   logic [7:0]   nxt_wcnt [2];
   logic [15:0]  diag_ff, nxt_diag, diag_set;
   logic         nxt_stim_pos, nxt_stim_neg, nxt_chk_start;
   logic         nxt_gp1, nxt_gp1_oe, nxt_gp2, nxt_gp2_oe, alarm_level;

   serial_link u_link (
      .rstn_i      (RSTN_I),
      .sclk_i      (SCLK_I),
      .cs_n_i      (CS_N_I),
      .din_i       (DIN_I),
      .tx_word_i   (tx_ff),
      .dout_o      (DOUT_O),
      .rx_word_o   (rx_word),
      .frame_tgl_o (frame_tgl)
   );

   // crossings: frame toggle, chip select and the two supply comparators
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         tgl_sync_ff <= 3'h0;
         cs_sync_ff  <= 3'h7;
         sup_s1_ff   <= 2'h0;
         sup_s2_ff   <= 2'h0;
      end else begin
         tgl_sync_ff <= {tgl_sync_ff[1:0], frame_tgl};
         cs_sync_ff  <= {cs_sync_ff[1:0], CS_N_I};
         sup_s1_ff   <= {SUPPLY_HIGH_I, SUPPLY_LOW_I};
         sup_s2_ff   <= sup_s1_ff;
      end
   end

   assign frame_evt    = tgl_sync_ff[1] ^ tgl_sync_ff[2];
   assign cs_rise      = cs_sync_ff[1] & ~cs_sync_ff[2];
   assign cmd_adr      = rx_word[14:8];
   assign cmd_word_adr = {cmd_adr[6:1], 1'b0};
   assign wr_evt       = frame_evt & rx_word[15];
   assign rd_evt       = frame_evt & ~rx_word[15];
   assign diag_rd      = rd_evt & (cmd_word_adr == `ADR_DIAG);
   // short frame is a link failure
   assign comm_evt     = cs_rise & ~(seen_ff | frame_evt);
   assign st_done      = (st_ff == ST_EVAL);
   assign mem_done     = (st_ff == ST_MEM) & FLASH_CHK_DONE_I;

   // register file: byte writes, word reads answered in the next frame
   always_comb begin
      nxt_thr  = thr_ff;
      nxt_smp  = smp_ff;
      nxt_actl = actl_ff;
      nxt_msc  = msc_ff;
      nxt_tx   = tx_ff;
      nxt_seen = cs_rise ? 1'b0 : (seen_ff | frame_evt);
      if (wr_evt) begin
         case (cmd_word_adr)
            `ADR_THR1: nxt_thr[0] = put_byte(thr_ff[0], cmd_adr[0], rx_word[7:0]);
            `ADR_THR2: nxt_thr[1] = put_byte(thr_ff[1], cmd_adr[0], rx_word[7:0]);
            `ADR_SMP1: if (!cmd_adr[0]) nxt_smp[0] = rx_word[7:0];
            `ADR_SMP2: if (!cmd_adr[0]) nxt_smp[1] = rx_word[7:0];
            `ADR_ACTL: nxt_actl = put_byte(actl_ff, cmd_adr[0], rx_word[7:0]);
            `ADR_MSC:  nxt_msc  = put_byte(msc_ff, cmd_adr[0], rx_word[7:0]);
            default:   nxt_msc  = nxt_msc;
         endcase
      end
      if (st_done) nxt_msc[`MSC_SELFTEST] = 1'b0;
      if (mem_done) nxt_msc[`MSC_MEMTEST] = 1'b0;
      if (rd_evt) begin
         case (cmd_word_adr)
            `ADR_THR1: nxt_tx = thr_ff[0];
            `ADR_THR2: nxt_tx = thr_ff[1];
            `ADR_SMP1: nxt_tx = {8'h00, smp_ff[0]};
            `ADR_SMP2: nxt_tx = {8'h00, smp_ff[1]};
            `ADR_ACTL: nxt_tx = actl_ff;
            `ADR_MSC:  nxt_tx = msc_ff;
            `ADR_DIAG: nxt_tx = diag_ff;
            default:   nxt_tx = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         thr_ff[0] <= `RST_ZERO;
         thr_ff[1] <= `RST_ZERO;
         smp_ff[0] <= 8'h00;
         smp_ff[1] <= 8'h00;
         actl_ff   <= `RST_ZERO;
         msc_ff    <= `RST_MSC;
         tx_ff     <= 16'h0000;
         seen_ff   <= 1'b0;
      end else begin
         thr_ff  <= nxt_thr;
         smp_ff  <= nxt_smp;
         actl_ff <= nxt_actl;
         msc_ff  <= nxt_msc;
         tx_ff   <= nxt_tx;
         seen_ff <= nxt_seen;
      end
   end

   // self-test and memory test sequencer
   always_comb begin
      nxt_st        = st_ff;
      nxt_cnt       = cnt_ff;
      nxt_axis_fail = axis_fail_ff;
      nxt_chk_start = 1'b0;
      case (st_ff)
         ST_IDLE: begin
            if (msc_ff[`MSC_SELFTEST]) begin
               nxt_st  = ST_POS;
               nxt_cnt = 8'h00;
            end else if (msc_ff[`MSC_MEMTEST]) begin
               nxt_st        = ST_MEM;
               nxt_chk_start = 1'b1;
            end
         end
         ST_POS, ST_NEG: begin
            if (SAMPLE_TICK_I) begin
               nxt_cnt = cnt_ff + 8'h01;
               if (cnt_ff >= ST_PHASE_TICKS - 8'h01) begin
                  nxt_cnt = 8'h00;
                  nxt_st  = (st_ff == ST_POS) ? ST_NEG : ST_EVAL;
                  if (st_ff == ST_NEG) nxt_axis_fail = ST_AXIS_FAIL_I;
               end
            end
         end
         ST_EVAL: nxt_st = ST_IDLE;
         ST_MEM:  if (FLASH_CHK_DONE_I) nxt_st = ST_IDLE;
         default: nxt_st = ST_IDLE;
      endcase
      nxt_stim_pos = msc_ff[`MSC_POS] | (nxt_st == ST_POS);
      nxt_stim_neg = msc_ff[`MSC_NEG] | (nxt_st == ST_NEG);
   end

   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         st_ff             <= ST_IDLE;
         cnt_ff            <= 8'h00;
         axis_fail_ff      <= 6'h00;
         FLASH_CHK_START_O <= 1'b0;
         STIM_POS_O        <= 1'b0;
         STIM_NEG_O        <= 1'b0;
      end else begin
         st_ff             <= nxt_st;
         cnt_ff            <= nxt_cnt;
         axis_fail_ff      <= nxt_axis_fail;
         FLASH_CHK_START_O <= nxt_chk_start;
         STIM_POS_O        <= nxt_stim_pos;
         STIM_NEG_O        <= nxt_stim_neg;
      end
   end

   // two alarms evaluated on sample ticks, a rate alarm once per window of samples
   always_comb begin
      logic [3:0]         src;
      logic               roc;
      sample_t            val;
      logic signed [14:0] thr_v, delta;
      src   = 4'h0;
      roc   = 1'b0;
      val   = 14'h0000;
      thr_v = 15'sh0000;
      delta = 15'sh0000;
      nxt_alm  = alm_ff;
      nxt_snap = snap_ff;
      nxt_wcnt = wcnt_ff;
      for (int i = 0; i < 2; i++) begin
         src = (i == 1) ? actl_ff.src2 : actl_ff.src1;
         roc   = (i == 1) ? actl_ff.roc2 : actl_ff.roc1;
         val   = pick_src(actl_ff.filt ? SENS_FILT_I : SENS_RAW_I, src);
         thr_v = {thr_ff[i][13], thr_ff[i][13:0]};
         delta = 15'({val[13], val} - {snap_ff[i][13], snap_ff[i]});
         if (SAMPLE_TICK_I) begin
            if (src == 4'h0) begin
               nxt_alm[i] = 1'b0;
            end else if (!roc) begin
               nxt_alm[i] = over_thr(thr_ff[i][`THR_POL], {val[13], val}, thr_v);
            end else if (wcnt_ff[i] + 8'h01 >= eff_count(smp_ff[i])) begin
               nxt_alm[i]  = over_thr(thr_ff[i][`THR_POL], delta, thr_v);
               nxt_snap[i] = val;
               nxt_wcnt[i] = 8'h00;
            end else begin
               nxt_wcnt[i] = wcnt_ff[i] + 8'h01;
            end
         end
      end
      alarm_level = (|alm_ff) == actl_ff.out_pol;
      nxt_gp1     = alarm_level;
      nxt_gp2     = alarm_level;
      nxt_gp1_oe  = actl_ff.out_en & ~actl_ff.out_sel;
      nxt_gp2_oe  = actl_ff.out_en & actl_ff.out_sel;
   end

   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         alm_ff         <= 2'h0;
         snap_ff[0]     <= 14'h0000;
         snap_ff[1]     <= 14'h0000;
         wcnt_ff[0]     <= 8'h00;
         wcnt_ff[1]     <= 8'h00;
         GP_LINE_1_O    <= 1'b0;
         GP_LINE_1_OE_O <= 1'b0;
         GP_LINE_2_O    <= 1'b0;
         GP_LINE_2_OE_O <= 1'b0;
      end else begin
         alm_ff         <= nxt_alm;
         snap_ff        <= nxt_snap;
         wcnt_ff        <= nxt_wcnt;
         GP_LINE_1_O    <= nxt_gp1;
         GP_LINE_1_OE_O <= nxt_gp1_oe;
         GP_LINE_2_O    <= nxt_gp2;
         GP_LINE_2_OE_O <= nxt_gp2_oe;
      end
   end

   // diagnostic status: sticky flags except the live supply bits 1:0, set wins over read clear
   always_comb begin
      diag_set = 16'h0000;
      if (st_done) diag_set[15:10] = axis_fail_ff;
      diag_set[`DG_STERR] = st_done & (|axis_fail_ff);
      diag_set[`DG_ALM2]  = SAMPLE_TICK_I & alm_ff[1];
      diag_set[`DG_ALM1]  = SAMPLE_TICK_I & alm_ff[0];
      diag_set[`DG_FLASH] = mem_done & FLASH_CHK_FAIL_I;
      diag_set[`DG_OVR]   = SAMPLE_TICK_I & OVERRANGE_I;
      diag_set[`DG_COMM]  = comm_evt;
      diag_set[`DG_FUPD]  = SAMPLE_TICK_I & FLASH_UPD_FAIL_I;
      nxt_diag = (diag_rd ? 16'h0000 : diag_ff) | diag_set;
      nxt_diag[`DG_UNUSED] = 1'b0;
      nxt_diag[1:0] = sup_s2_ff;
   end

   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         diag_ff <= `RST_ZERO;
      end else begin
         diag_ff <= nxt_diag;
      end
   end

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RSTN_I);

   sequence s_selftest_start;
      st_ff == ST_IDLE && msc_ff[`MSC_SELFTEST];
   endsequence
   sequence s_full_test;
      st_ff == ST_NEG && SAMPLE_TICK_I && cnt_ff == ST_PHASE_TICKS - 8'h01 ##1 st_ff == ST_EVAL;
   endsequence

   AST_SELFTEST_RUNS: assert property (s_selftest_start |=> st_ff == ST_POS && STIM_POS_O)
      else $error("self-test did not start stimulus");
   AST_SELFTEST_CLEARS: assert property (s_full_test |=> !msc_ff[`MSC_SELFTEST]
      && (diag_ff[15:10] & $past(axis_fail_ff)) == $past(axis_fail_ff))
      else $error("self-test bit or axis flags wrong after completion");
   AST_MANUAL_NEG: assert property (msc_ff[`MSC_NEG] |=> STIM_NEG_O)
      else $error("negative stimulus not applied");
   AST_MEM_RESULT: assert property (mem_done && FLASH_CHK_FAIL_I |=> diag_ff[`DG_FLASH]
      && !msc_ff[`MSC_MEMTEST])
      else $error("checksum failure not reported");
   AST_READ_CLEARS: assert property (diag_rd && diag_set == 16'h0000 |=> diag_ff[15:2] == 14'h0)
      else $error("status read did not clear flags");
   AST_OVR_RETURNS: assert property (SAMPLE_TICK_I && OVERRANGE_I |=> diag_ff[`DG_OVR])
      else $error("overrange flag not set again");
   AST_SUPPLY_FOLLOW: assert property (diag_ff[1:0] == $past(sup_s2_ff))
      else $error("supply flags do not follow the comparators");
   AST_BIT7_ZERO: assert property (rd_evt && cmd_word_adr == `ADR_DIAG |=> !tx_ff[`DG_UNUSED])
      else $error("unused status bit read as one");
   AST_ALARM_OFF: assert property (SAMPLE_TICK_I && actl_ff.src1 == 4'h0
      |=> !alm_ff[0] ##1 (GP_LINE_1_O != $past(actl_ff.out_pol) || $past(alm_ff[1])))
      else $error("disabled alarm went active");
   AST_LINE_ROUTE: assert property (actl_ff.out_en && !actl_ff.out_sel
      |=> GP_LINE_1_OE_O && !GP_LINE_2_OE_O)
      else $error("alarm line routing wrong");
   AST_WINDOW_BOUND: assert property (SAMPLE_TICK_I && actl_ff.roc2
      && actl_ff.src2 != 4'h0 |=> wcnt_ff[1] < eff_count(smp_ff[1]) || $changed(smp_ff[1]))
      else $error("rate window exceeded its count");
endmodule : idam_monitor

// ### verification/spi_host.sv
// host-side serial master model for the monitor's link
`timescale 1ns/1ns
module spi_host (
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      din_o,
   input  wire logic dout_i
);
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      din_o  = 1'b0;
   end
   // one frame, msb first; the clock stands still between frames
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      #37;
      cs_n_o = 1'b0;
      #60;
      for (int i = 15; i >= 0; i--) begin
         sclk_o = 1'b0;
         din_o  = w[i];
         #80;
         sclk_o = 1'b1;
         r[i]   = dout_i;
         #80;
      end
      #60;
      cs_n_o = 1'b1;
      // released line shows the inverse of its last bit
      din_o = ~din_o;
      #300;
   endtask : xfer
   // a cut frame: chip select falls for a few clocks only
   task automatic cut_frame(input int n);
      #37;
      cs_n_o = 1'b0;
      #60;
      repeat (n) begin
         sclk_o = 1'b0;
         #80;
         sclk_o = 1'b1;
         #80;
      end
      #60;
      cs_n_o = 1'b1;
      #300;
   endtask : cut_frame
endmodule : spi_host

// ### verification/tb_top.sv
// self-checking bench for the diagnostics and alarm monitor
`timescale 1ns/1ns
`include "idam_defs.svh"
module tb_top;
   import idam_pkg::*;
   logic        clk = 1'b0, rstn = 1'b0, sclk, cs_n, din, dout, tick;
   logic [3:0]  tcnt = 4'h0;
   sensor_set_s raw = '0, filt = '0;
   logic [5:0]  axf = 6'h00;
   logic        shi = 1'b0, slo = 1'b0, ovr = 1'b0, fupd = 1'b0, cdone = 1'b0, cfail = 1'b0;
   logic        spos, sneg, cstart, g1, g1oe, g2, g2oe;
   int          n_errors = 0, tests_run = 0, n_start = 0, n_pos = 0, n_neg = 0;
   always #10 clk = ~clk;
   always @(posedge clk) tcnt <= (tcnt == 4'h9) ? 4'h0 : tcnt + 4'h1;
   assign tick = (tcnt == 4'h9);
   always @(posedge clk) begin
      n_start <= n_start + int'(cstart === 1'b1);
      n_pos   <= n_pos + int'(spos === 1'b1);
      n_neg   <= n_neg + int'(sneg === 1'b1);
      // both stimulus directions at once is never legal
      if (spos === 1'b1 && sneg === 1'b1) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, {spos, sneg}, 2'h0);
      end
   end
   spi_host u_spi_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));
   idam_monitor #(.ST_PHASE_TICKS(8'h02)) u_idam_monitor (
      .SYS_CLK_I(clk), .RSTN_I(rstn), .SCLK_I(sclk), .CS_N_I(cs_n), .DIN_I(din),
      .DOUT_O(dout), .SAMPLE_TICK_I(tick), .SENS_RAW_I(raw), .SENS_FILT_I(filt),
      .ST_AXIS_FAIL_I(axf), .SUPPLY_HIGH_I(shi), .SUPPLY_LOW_I(slo), .OVERRANGE_I(ovr),
      .FLASH_UPD_FAIL_I(fupd), .FLASH_CHK_DONE_I(cdone), .FLASH_CHK_FAIL_I(cfail),
      .STIM_POS_O(spos), .STIM_NEG_O(sneg), .FLASH_CHK_START_O(cstart),
      .GP_LINE_1_O(g1), .GP_LINE_1_OE_O(g1oe), .GP_LINE_2_O(g2), .GP_LINE_2_OE_O(g2oe));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [15:0] r;
      u_spi_host.xfer({1'b1, a, d}, r);
   endtask : wr
   // answer arrives in the following frame, a harmless control read
   task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
      logic [15:0] r;
      u_spi_host.xfer({1'b0, a, 8'h00}, r);
      u_spi_host.xfer({1'b0, `ADR_MSC, 8'h00}, r);
      chk(r, exp);
   endtask : rdc
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic t_reset;
      // idle alarm with low polarity leaves both lines high but undriven
      chk(16'({spos, sneg, cstart, g1, g1oe, g2, g2oe}), 16'h000A);
      rdc(`ADR_MSC, `RST_MSC);
      rdc(`ADR_THR1, 16'h0000);
      rdc(`ADR_SMP2, 16'h0000);
      rdc(`ADR_ACTL, 16'h0000);
      rdc(`ADR_DIAG, 16'h0000);
      rdc(7'h40, 16'h0000);
      wr(7'h27, 8'h80);
      wr(7'h26, 8'h32);
      rdc(`ADR_THR1, 16'h8032);
      wr(7'h2B, 8'hFF);
      rdc(`ADR_SMP1, 16'h0000);
   endtask : t_reset
   task automatic t_selftest;
      cyc(1);
      axf = 6'b100001;
      wr(7'h35, 8'h04);
      // sensor inputs stay still for the whole routine
      cyc(120);
      chk(16'(n_pos > 0 && n_neg > 0), 16'h0001);
      rdc(`ADR_MSC, `RST_MSC);
      rdc(`ADR_DIAG, 16'h8420);
      rdc(`ADR_DIAG, 16'h0000);
      cyc(1);
      axf = 6'h00;
   endtask : t_selftest
   task automatic t_manual;
      wr(7'h35, 8'h02);
      cyc(8);
      chk(16'({spos, sneg}), 16'h0001);
      wr(7'h35, 8'h01);
      cyc(8);
      chk(16'({spos, sneg}), 16'h0002);
      wr(7'h35, 8'h00);
      cyc(8);
      chk(16'({spos, sneg}), 16'h0000);
   endtask : t_manual
   task automatic t_memtest;
      wr(7'h35, 8'h08);
      chk(16'(n_start), 16'h0001);
      cyc(1);
      cdone = 1'b1;
      cfail = 1'b1;
      cyc(1);
      cdone = 1'b0;
      cyc(4);
      rdc(`ADR_MSC, `RST_MSC);
      rdc(`ADR_DIAG, 16'h0040);
   endtask : t_memtest
   task automatic t_supply;
      cyc(1);
      shi = 1'b1;
      ovr = 1'b1;
      cyc(20);
      rdc(`ADR_DIAG, 16'h0012);
      rdc(`ADR_DIAG, 16'h0012);
      cyc(1);
      {shi, slo, ovr} = 3'b010;
      cyc(20);
      rdc(`ADR_DIAG, 16'h0011);
      rdc(`ADR_DIAG, 16'h0001);
      slo = 1'b0;
      cyc(20);
      rdc(`ADR_DIAG, 16'h0000);
   endtask : t_supply
   task automatic t_faults;
      cyc(1);
      fupd = 1'b1;
      cyc(20);
      fupd = 1'b0;
      // chip select window too short to carry a word
      u_spi_host.cut_frame(4);
      rdc(`ADR_DIAG, 16'h000C);
      rdc(`ADR_DIAG, 16'h0000);
   endtask : t_faults
   task automatic t_alarm;
      cyc(1);
      raw.ch[4] = 14'd100;
      wr(7'h2F, 8'h05);
      wr(7'h2E, 8'h06);
      cyc(20);
      chk(16'({g1oe, g1, g2oe}), 16'h0006);
      rdc(`ADR_DIAG, 16'h0100);
      cyc(1);
      raw.ch[4] = 14'd20;
      wr(7'h2E, 8'h05);
      cyc(20);
      chk(16'({g2oe, g2, g1oe}), 16'h0006);
      cyc(1);
      filt.ch[4] = 14'd100;
      wr(7'h2E, 8'h17);
      cyc(20);
      chk(16'({g2oe, g2}), 16'h0003);
      wr(7'h2F, 8'h65);
      wr(7'h2E, 8'h86);
      wr(7'h29, 8'h80);
      wr(7'h28, 8'h0A);
      // alarm 1 was active on filtered data, so its flag is still held
      rdc(`ADR_DIAG, 16'h0100);
      cyc(1);
      raw.ch[5] = 14'd40;
      cyc(40);
      rdc(`ADR_DIAG, 16'h0200);
      rdc(`ADR_DIAG, 16'h0000);
      // slow ramp: one sample never moves enough, three samples do
      wr(7'h2C, 8'h03);
      repeat (8) begin
         cyc(10);
         raw.ch[5] = raw.ch[5] + 14'd5;
      end
      rdc(`ADR_DIAG, 16'h0200);
   endtask : t_alarm
   task automatic tally_and_finish;
      if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   initial begin
      // about twice the length of all scenarios together
      #400000;
      n_errors++;
      tally_and_finish();
   end
   initial begin
      cyc(8);
      rstn = 1'b1;
      cyc(4);
      t_reset();
      t_selftest();
      t_manual();
      t_memtest();
      t_supply();
      t_faults();
      t_alarm();
      tally_and_finish();
   end
endmodule : tb_top
